//--- verilog/reset_source_control.sv
// Reset source controller: selection code, reset causes, status flags.
// Assumes the core, watchdog and sleep logic run on pclk; only the
// low-voltage comparator output is asynchronous.
`timescale 1ns/1ns
module reset_source_control
    import rst_src_pkg::*;
#(
    parameter int UV_FILTER_NS = UV_FILTER_NS_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        lv_detect,
    input  wire logic        sleep_mode,
    input  wire logic        wdt_timeout,
    input  wire logic        wdt_code_fault,
    output logic             sys_reset,
    output logic             pc_sp_clear,
    output logic             lvr_enable,
    output logic             watchdog_timeout_flag,
    output logic             powerdown_flag,
    output por_act_t         por_actions,
    output logic             irq
);

    // ==========================================================
    // Derived counts
    localparam int UV_CYC_RAW =
        (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [23:0] UV_FILTER_CNT =
        24'(UV_CYC_RAW < 1 ? 1 : UV_CYC_RAW);

    // ==========================================================
    // Decode functions
    function automatic logic code_is_bad(input logic [7:0] c);
        code_is_bad = (c != LVR_CODE_EN) && (c != LVR_CODE_DIS);
    endfunction

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] o);
        hit = (a == o);
    endfunction

    // ==========================================================
    // Declarations
    logic [31:0]      prdata_q;
    logic [31:0]      rdata_d;
    logic             pready_q;
    logic             pslverr_q;
    logic             mapped_d;
    logic             wr_en;
    logic             lv_meta_q;
    logic             lv_sync_q;
    logic [7:0]       lvr_select_code_q;
    logic             lvr_enable_q;
    logic [23:0]      uv_cnt_q;
    logic             uv_fire;
    logic             code_bad;
    seq_state_t       state_q;
    seq_state_t       state_d;
    logic [15:0]      cnt_q;
    logic [15:0]      cnt_d;
    logic             soft_lvr_q;
    logic             restore_code;
    logic             sys_reset_q;
    logic             por_pend_q;
    logic             por_pend_d;
    por_act_t         por_act_q;
    cause_t           cause_q;
    cause_t           cause_set;
    logic [2:0]       cause_clr;
    logic             to_q;
    logic             pdf_q;
    logic             pc_sp_clear_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_stat_d;
    logic             irq_q;

    // ==========================================================
    // APB slave
    // Write happens at the completing access edge only
    assign wr_en = psel && penable && pready_q && pwrite;

    // Read mux and address decode
    always_comb begin
        rdata_d  = 32'h0000_0000;
        mapped_d = 1'b1;
        if (hit(paddr, OFS_LVR_SEL)) begin
            rdata_d[7:0] = lvr_select_code_q;
        end else if (hit(paddr, OFS_CAUSE)) begin
            rdata_d[2:0] = cause_q;   // Bits above stay zero
        end else if (hit(paddr, OFS_STATUS)) begin
            rdata_d[STAT_TO_BIT]  = to_q;
            rdata_d[STAT_PDF_BIT] = pdf_q;
        end else if (hit(paddr, OFS_IRQ_STAT)) begin
            rdata_d[IRQ_W-1:0] = irq_stat_q;
        end else if (hit(paddr, OFS_IRQ_CLR)) begin
            rdata_d = 32'h0000_0000;
        end else if (hit(paddr, OFS_IRQ_EN)) begin
            rdata_d[IRQ_W-1:0] = irq_en_q;
        end else begin
            mapped_d = 1'b0;
        end
    end

    // One wait state, then answer with data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel && penable && !pready_q;
            if (psel && penable && !pready_q) begin
                prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
                pslverr_q <= !mapped_d;
            end else begin
                prdata_q  <= 32'h0000_0000;
                pslverr_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Low-voltage input synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_meta_q <= 1'b0;
            lv_sync_q <= 1'b0;
        end else begin
            lv_meta_q <= lv_detect;
            lv_sync_q <= lv_meta_q;
        end
    end

    // ==========================================================
    // Selection code register
    assign code_bad     = code_is_bad(lvr_select_code_q);
    assign restore_code = (state_q == ST_SOFT_WAIT) &&
                          (cnt_q == SOFT_DLY_CNT - 16'h0001) &&
                          soft_lvr_q && !uv_fire;

    // Restore wins over a write; undervolt reset keeps it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvr_select_code_q <= LVR_SEL_POR;
        end else if (restore_code) begin
            lvr_select_code_q <= LVR_SEL_POR;
        end else if (wr_en && hit(paddr, OFS_LVR_SEL)) begin
            lvr_select_code_q <= pwdata[7:0];
        end
    end

    // Enable only on the enable code and never in sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvr_enable_q <= 1'b0;
        end else begin
            lvr_enable_q <= (lvr_select_code_q == LVR_CODE_EN)
                         && !sleep_mode;
        end
    end

    // ==========================================================
    // Undervolt filter: fire once low voltage outlasts filter
    assign uv_fire = lvr_enable_q && lv_sync_q &&
                     (uv_cnt_q == UV_FILTER_CNT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_cnt_q <= 24'h00_0000;
        end else if (!(lvr_enable_q && lv_sync_q) ||
                     state_q == ST_RESET) begin
            uv_cnt_q <= 24'h00_0000;
        end else if (uv_cnt_q != UV_FILTER_CNT) begin
            uv_cnt_q <= uv_cnt_q + 24'h00_0001;
        end
    end

    // ==========================================================
    // Reset sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_RUN: begin
                cnt_d = 16'h0000;
                if (uv_fire) begin
                    state_d = ST_RESET;
                end else if (code_bad || wdt_code_fault) begin
                    state_d = ST_SOFT_WAIT;
                end else if (wdt_timeout && !sleep_mode) begin
                    state_d = ST_RESET;
                end
            end
            ST_SOFT_WAIT: begin
                if (uv_fire) begin
                    state_d = ST_RESET;
                    cnt_d   = 16'h0000;
                end else if (cnt_q == SOFT_DLY_CNT - 16'h0001) begin
                    state_d = ST_RESET;
                    cnt_d   = 16'h0000;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            ST_RESET: begin
                if (cnt_q == RST_HOLD_CNT - 16'h0001) begin
                    state_d = ST_RUN;
                    cnt_d   = 16'h0000;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            default: begin
                state_d = ST_RESET;
                cnt_d   = 16'h0000;
            end
        endcase
    end

    // State, counter and merged reset output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= ST_RESET;
            cnt_q       <= 16'h0000;
            sys_reset_q <= 1'b1;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            sys_reset_q <= (state_d == ST_RESET);
        end
    end

    // Remember whether the pending soft reset is a selection code fault
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_lvr_q <= 1'b0;
        end else if (state_q == ST_RUN) begin
            soft_lvr_q <= code_bad;
        end
    end

    // ==========================================================
    // Power-on initialisation commands
    assign por_pend_d = por_pend_q &&
                        !(state_q == ST_RESET && state_d == ST_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_pend_q <= 1'b1;
            por_act_q  <= '1;
        end else begin
            por_pend_q <= por_pend_d;
            por_act_q.int_en_clear <= por_pend_d;
            por_act_q.io_dir_input <= por_pend_d;
            por_act_q.timer_off    <= por_pend_d;
            por_act_q.wdt_tb_clear <= por_pend_d;
            por_act_q.wdt_start    <= por_pend_d;
            por_act_q.sp_to_top    <= por_pend_d;
        end
    end

    // ==========================================================
    // Reset cause flags: set wins over a clear
    assign cause_set.undervolt_reset_flag = uv_fire;
    assign cause_set.lvr_code_fault_flag  = code_bad;
    assign cause_set.wdt_code_fault_flag  = wdt_code_fault;
    assign cause_clr = (wr_en && hit(paddr, OFS_CAUSE)) ?
                       ~pwdata[2:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= '0;
        end else begin
            cause_q <= (cause_q & ~cause_clr) | cause_set;
        end
    end

    // ==========================================================
    // Timeout and powerdown flags; undervolt leaves them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_q          <= 1'b0;
            pdf_q         <= 1'b0;
            pc_sp_clear_q <= 1'b0;
        end else begin
            pc_sp_clear_q <= wdt_timeout && sleep_mode;
            if (wdt_timeout) begin
                to_q <= 1'b1;
                if (sleep_mode) begin
                    pdf_q <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Interrupt status, clear and enable
    assign irq_evt[IRQ_UV]   = uv_fire;
    assign irq_evt[IRQ_LVR_LEVEL_SELECT] = code_bad && (state_q == ST_RUN);
    assign irq_evt[IRQ_WDTC] = wdt_code_fault;
    assign irq_evt[IRQ_WDTO] = wdt_timeout;
    assign irq_clr = (wr_en && hit(paddr, OFS_IRQ_CLR)) ?
                     pwdata[IRQ_W-1:0] : '0;
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
            irq_en_q   <= '0;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_en && hit(paddr, OFS_IRQ_EN)) begin
                irq_en_q <= pwdata[IRQ_W-1:0];
            end
            irq_q <= |(irq_stat_d & irq_en_q);
        end
    end

    // ==========================================================
    // Outputs straight from flops
    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign sys_reset             = sys_reset_q;
    assign pc_sp_clear           = pc_sp_clear_q;
    assign lvr_enable            = lvr_enable_q;
    assign watchdog_timeout_flag = to_q;
    assign powerdown_flag        = pdf_q;
    assign por_actions           = por_act_q;
    assign irq                   = irq_q;

endmodule

//--- verilog/rst_src_pkg.sv
// Constants, types and register map of the reset source controller.
// Assumes a single 50 MHz system clock and an APB register port.
package rst_src_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS       = 20;
    localparam int SOFT_RESET_DELAY_NS = 40000;
    // Least time, rounded up, never under one cycle
    localparam int SOFT_DLY_CYC =
        ((SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ?
        1 : ((SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] SOFT_DLY_CNT = 16'(SOFT_DLY_CYC);
    localparam logic [15:0] RST_HOLD_CNT = 16'h0004;
    localparam int          UV_FILTER_NS_DEF = 100000;

    // ==========================================================
    // Selection codes
    localparam logic [7:0] LVR_CODE_EN  = 8'h5a;
    localparam logic [7:0] LVR_CODE_DIS = 8'ha5;
    localparam logic [7:0] LVR_SEL_POR  = 8'h5a;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFS_LVR_SEL  = 12'h000;
    localparam logic [11:0] OFS_CAUSE    = 12'h004;
    localparam logic [11:0] OFS_STATUS   = 12'h008;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h00c;
    localparam logic [11:0] OFS_IRQ_CLR  = 12'h010;
    localparam logic [11:0] OFS_IRQ_EN   = 12'h014;

    // ==========================================================
    // Field positions
    localparam int STAT_PDF_BIT = 0;
    localparam int STAT_TO_BIT  = 1;
    localparam int IRQ_UV       = 0;
    localparam int IRQ_LVR_LEVEL_SELECT     = 1;
    localparam int IRQ_WDTC     = 2;
    localparam int IRQ_WDTO     = 3;
    localparam int IRQ_W        = 4;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_RUN       = 2'b00,
        ST_SOFT_WAIT = 2'b01,
        ST_RESET     = 2'b10
    } seq_state_t;

    // Reset cause flags, bit 2 down to bit 0
    typedef struct packed {
        logic undervolt_reset_flag;
        logic lvr_code_fault_flag;
        logic wdt_code_fault_flag;
    } cause_t;

    // Power-on initialisation commands to the core
    typedef struct packed {
        logic int_en_clear;
        logic io_dir_input;
        logic timer_off;
        logic wdt_tb_clear;
        logic wdt_start;
        logic sp_to_top;
    } por_act_t;

endpackage

//--- verification/reset_source_monitor.sv
// Port checker of the reset source controller.
// Assumes one pclk domain; bound into the design top module.
`timescale 1ns/1ns
module reset_source_monitor
    import rst_src_pkg::*;
#(
    parameter int UV_FILTER_NS = UV_FILTER_NS_DEF
) (
    input wire logic     pclk,
    input wire logic     presetn,
    input wire logic     sleep_mode,
    input wire logic     wdt_timeout,
    input wire logic     wdt_code_fault,
    input wire logic     sys_reset,
    input wire logic     pc_sp_clear,
    input wire logic     lvr_enable,
    input wire logic     watchdog_timeout_flag,
    input wire logic     powerdown_flag,
    input wire por_act_t por_actions
);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_POR_INIT: assert property (
        $rose(presetn) |-> (por_actions == '1 && sys_reset)[*4]
        ##1 (por_actions == '0 && !sys_reset))
        else $error("power-on actions or hold wrong");
    AST_RST_HOLD: assert property (
        $rose(sys_reset) |-> sys_reset[*4] ##1 !sys_reset)
        else $error("system reset hold wrong");
    AST_RUN_TO: assert property (
        wdt_timeout && !sleep_mode && !sys_reset |=>
        watchdog_timeout_flag && sys_reset && $stable(powerdown_flag))
        else $error("run timeout handling wrong");
    AST_SLEEP_TO: assert property (
        wdt_timeout && sleep_mode && !sys_reset |=> pc_sp_clear
        && watchdog_timeout_flag && powerdown_flag && !sys_reset)
        else $error("sleep timeout handling wrong");
    AST_PCSP_CAUSE: assert property (
        pc_sp_clear |-> $past(wdt_timeout) && $past(sleep_mode))
        else $error("pc and sp clear without sleep timeout");
    AST_LVR_SLEEP: assert property (
        sleep_mode |=> !lvr_enable)
        else $error("low voltage reset armed in sleep");
    AST_NO_EARLY: assert property (
        $rose(wdt_code_fault) && !sys_reset |=> !sys_reset[*8])
        else $error("code fault reset came too early");
    AST_FLAGS_KEEP: assert property (
        $rose(sys_reset) && !$past(wdt_timeout) |->
        $stable(watchdog_timeout_flag) && $stable(powerdown_flag))
        else $error("status flags changed on other reset");
endmodule

bind reset_source_control reset_source_monitor #(
    .UV_FILTER_NS(UV_FILTER_NS)
) mon_u (
    .pclk, .presetn, .sleep_mode, .wdt_timeout, .wdt_code_fault,
    .sys_reset, .pc_sp_clear, .lvr_enable, .watchdog_timeout_flag,
    .powerdown_flag, .por_actions
);

//--- verification/core_model.sv
// Core side model: watchdog, sleep and comparator sources.
// Assumes requests from the bench arrive on pclk rising edges.
`timescale 1ns/1ns
module core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       lv_req,
    input  wire logic       sleep_req,
    input  wire logic       to_req,
    input  wire logic       wf_req,
    input  wire logic       sys_reset,
    input  wire logic       pc_sp_clear,
    output logic            lv_detect,
    output logic            sleep_mode,
    output logic            wdt_timeout,
    output logic            wdt_code_fault,
    output logic      [7:0] rst_count,
    output logic      [7:0] pcsp_count
);
    logic rst_prev_q;

    // Event sources, launched just after the clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_detect      <= 1'b0;
            sleep_mode     <= 1'b0;
            wdt_timeout    <= 1'b0;
            wdt_code_fault <= 1'b0;
        end else begin
            lv_detect      <= lv_req;
            sleep_mode     <= sleep_req;
            wdt_timeout    <= to_req;
            wdt_code_fault <= wf_req;
        end
    end

    // Counts resets and pc/sp clears the core receives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_prev_q <= 1'b1;
            rst_count  <= 8'h00;
            pcsp_count <= 8'h00;
        end else begin
            rst_prev_q <= sys_reset;
            rst_count  <= rst_count + 8'(sys_reset && !rst_prev_q);
            pcsp_count <= pcsp_count + 8'(pc_sp_clear);
        end
    end
endmodule

//--- verification/reset_source_control_tb.sv
// Self-checking bench of the reset source controller.
// Assumes APB master here and the core model on the far side.
`timescale 1ns/1ns
module reset_source_control_tb
    import rst_src_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        lv_detect, sleep_mode, wdt_timeout, wdt_code_fault;
    logic        sys_reset, pc_sp_clear, lvr_enable, irq;
    logic        watchdog_timeout_flag, powerdown_flag;
    logic        lv_req, sleep_req, to_req, wf_req;
    logic [7:0]  rst_count, pcsp_count;
    por_act_t    por_actions;
    int          fail_count, cmp_count;

    reset_source_control #(.UV_FILTER_NS(200)) dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .lv_detect, .sleep_mode,
        .wdt_timeout, .wdt_code_fault, .sys_reset, .pc_sp_clear,
        .lvr_enable, .watchdog_timeout_flag, .powerdown_flag,
        .por_actions, .irq);
    core_model core_u (
        .pclk, .presetn, .lv_req, .sleep_req, .to_req, .wf_req,
        .sys_reset, .pc_sp_clear, .lv_detect, .sleep_mode, .wdt_timeout,
        .wdt_code_fault, .rst_count, .pcsp_count);

    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic timeout(input string nm);
        chk(nm, 32'h1, 32'h0);
        stop_test();
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // One APB transfer, released only after the pready edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Sample pready at each rising edge; take data at that edge
        do begin
            @(posedge pclk);
            n++;
            if (n > 20)
                timeout("pready");
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, x, r);
    endtask
    // Bounded wait for sys_reset to reach a level, counts cycles
    task automatic wait_rst(input logic lvl, input int lim,
                            output int n);
        n = 0;
        while (sys_reset !== lvl) begin
            @(negedge pclk);
            n++;
            if (n > lim)
                timeout("sys_reset wait");
        end
    endtask
    task automatic look(input string nm, input logic x, input int k);
        idle(k);
        @(negedge pclk);
        chk(nm, 32'(x), 32'(nm == "irq" ? irq : lvr_enable));
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_por;
        int n;
        logic [31:0] r;
        logic        e;
        @(negedge pclk);
        chk("por_act", 32'h3f, 32'(por_actions));
        wait_rst(1'b0, 10, n);
        chk("por_actions off", 32'h0, 32'(por_actions));
        chk("lvr_enable", 32'h1, 32'(lvr_enable));
        rd("code", OFS_LVR_SEL, 32'h5a);
        rd("cause", OFS_CAUSE, 32'h0);
        rd("status", OFS_STATUS, 32'h0);
        rd("irq_en", OFS_IRQ_EN, 32'h0);
        apb(1'b0, 12'h0ff, 32'h0, r, e);
        chk("unmapped err", 32'h1, 32'(e));
        wr(OFS_LVR_SEL, 32'ha5);
        look("lvr_enable", 1'b0, 2);
        @(posedge pclk);
        lv_req <= 1'b1;
        idle(40);
        lv_req <= 1'b0;
        chk("no reset disabled", 32'h0, 32'(rst_count));
        wr(OFS_LVR_SEL, 32'h5a);
        look("lvr_enable", 1'b1, 2);
    endtask
    task automatic t_uv;
        int n;
        wr(OFS_IRQ_EN, 32'h1);
        lv_req <= 1'b1;
        idle(5);
        lv_req <= 1'b0;
        idle(30);
        chk("short dip", 32'h0, 32'(rst_count));
        lv_req <= 1'b1;
        wait_rst(1'b1, 60, n);
        @(posedge pclk);
        lv_req <= 1'b0;
        wait_rst(1'b0, 10, n);
        rd("cause uv", OFS_CAUSE, 32'h4);
        rd("code kept", OFS_LVR_SEL, 32'h5a);
        rd("status kept", OFS_STATUS, 32'h0);
        rd("irq stat", OFS_IRQ_STAT, 32'h1);
        look("irq", 1'b1, 1);
        wr(OFS_IRQ_EN, 32'h0);
        look("irq", 1'b0, 2);
        wr(OFS_IRQ_EN, 32'h1);
        look("irq", 1'b1, 2);
        wr(OFS_IRQ_CLR, 32'h1);
        look("irq", 1'b0, 2);
        wr(OFS_CAUSE, 32'hff);
        rd("cause one keeps", OFS_CAUSE, 32'h4);
        wr(OFS_CAUSE, 32'h0);
        rd("cause cleared", OFS_CAUSE, 32'h0);
    endtask
    task automatic t_soft(input logic code);
        int n;
        if (code)
            wr(OFS_LVR_SEL, 32'h00);
        else begin
            wf_req <= 1'b1;
            idle(1);
            wf_req <= 1'b0;
        end
        wait_rst(1'b1, SOFT_DLY_CYC + 10, n);
        chk("soft delay", 32'h1, 32'(n >= SOFT_DLY_CYC - 1 &&
            n <= SOFT_DLY_CYC + 2));
        wait_rst(1'b0, 10, n);
        rd("code restored", OFS_LVR_SEL, 32'h5a);
        rd("cause soft", OFS_CAUSE, code ? 32'h2 : 32'h1);
        wr(OFS_CAUSE, 32'h0);
        rd("cause cleared", OFS_CAUSE, 32'h0);
        rd("irq stat soft", OFS_IRQ_STAT, code ? 32'h2 : 32'h4);
        wr(OFS_IRQ_CLR, 32'hf);
        rd("irq stat clr", OFS_IRQ_STAT, 32'h0);
    endtask
    task automatic t_wdt;
        int n;
        logic [7:0] rc;
        to_req <= 1'b1;
        idle(1);
        to_req <= 1'b0;
        wait_rst(1'b1, 5, n);
        wait_rst(1'b0, 10, n);
        chk("reset hold", 32'(RST_HOLD_CNT), 32'(n));
        rd("status run", OFS_STATUS, 32'h2);
        chk("to flag", 32'h1, 32'(watchdog_timeout_flag));
        chk("pd flag run", 32'h0, 32'(powerdown_flag));
        rd("irq stat wdt", OFS_IRQ_STAT, 32'h8);
        sleep_req <= 1'b1;
        look("lvr_enable", 1'b0, 3);
        rc = rst_count;
        @(posedge pclk);
        to_req <= 1'b1;
        idle(1);
        to_req <= 1'b0;
        idle(4);
        rd("status sleep", OFS_STATUS, 32'h3);
        chk("pd flag sleep", 32'h1, 32'(powerdown_flag));
        chk("pc sp clears", 32'h1, 32'(pcsp_count));
        chk("no sleep reset", 32'(rc), 32'(rst_count));
        wr(OFS_STATUS, 32'h0);
        rd("status ro", OFS_STATUS, 32'h3);
        sleep_req <= 1'b0;
        presetn <= 1'b0;
        idle(3);
        presetn <= 1'b1;
        wait_rst(1'b0, 10, n);
        rd("status por", OFS_STATUS, 32'h0);
    endtask

    // ==========================================================
    // Clock, reset and main sequence
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {lv_req, sleep_req, to_req, wf_req} = '0;
        fail_count = 0;
        cmp_count = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_por();
        t_uv();
        t_soft(1'b1);
        t_soft(1'b0);
        t_wdt();
        stop_test();
    end
endmodule
